// file: dv/msl_host_model.sv
// Behavioural host that frames words onto the three-wire serial link.
`timescale 1ns/1ns
module msl_host_model (
    output logic sclk,
    output logic sync_n,
    output logic serial_data_in
);
    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    // The link clock is parked low and frame select stays high between frames.
    initial begin
        sclk = 1'h0;
        sync_n = 1'h1;
        serial_data_in = 1'h0;
    end

    // ------------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------------
    // Sends the low nb bits of w MSB first at a 160 ns bit period.
    // Frame select stays high when sel is clear, so the clocks are stray.
    task automatic send(input logic [16:0] w, input int nb, input bit sel, input bit rise);
        int i;
        #37;
        sync_n = ~sel;
        for (i = 0; i < nb; i++) begin
            sclk = ~rise;
            serial_data_in = w[nb-1-i];
            #80;
            sclk = rise;
            #80;
        end
        sclk = 1'h0;
        #80;
        sync_n = 1'h1;
        // Released data shows the inverse so a stale bit is never mistaken for data.
        serial_data_in = ~serial_data_in;
    endtask : send
endmodule : msl_host_model

// file: dv/msl_word_loader_bench.sv
// Self-checking bench for the serial word loader.
`timescale 1ns/1ns
module msl_word_loader_bench;
    import msl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic sclk, sync_n, serial_data_in, edge_rising, rise;
    logic [11:0] paddr, output_current_node, code;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] w;
    logic [7:0] frames;
    logic [1:0] res;
    int mismatches, checks_done, i, r;

    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    // Core clock at 20 MHz.
    initial pclk = 1'h0;
    always #25 pclk = ~pclk;

    msl_word_loader dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .sync_n(sync_n), .serial_data_in(serial_data_in),
        .output_current_node(output_current_node), .edge_rising(edge_rising));

    msl_host_model host (.sclk(sclk), .sync_n(sync_n), .serial_data_in(serial_data_in));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Compares a value seen with the value expected and counts both outcomes.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // One APB transfer; the answer is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'h1) begin
            mismatches++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Works out the DAC code that a load word gives at a resolution.
    function automatic logic [11:0] exp_code(input logic [15:0] x, input logic [1:0] rs);
        case (rs)
            RES_8: return {4'h0, x[13:6]};
            RES_10: return {2'h0, x[13:4]};
            default: return x[13:2];
        endcase
    endfunction : exp_code

    // Sends one frame, then allows the transfer into the core to land.
    task automatic frame(input logic [16:0] fw, input int nb, input bit sel);
        host.send(fw, nb, sel, rise);
        repeat (8) @(posedge pclk);
        if (sel) begin
            frames++;
        end
    endtask : frame

    // Checks the outputs and the status word against the expectations.
    task automatic expect_state(input logic [1:0] f);
        check("code", {20'h0, output_current_node}, {20'h0, code});
        check("edge", {31'h0, edge_rising}, {31'h0, rise});
        apb(1'h0, ADDR_STATUS, 32'h0);
        check("status", rd, {16'h0, frames, 5'h00, f, rise});
    endtask : expect_state

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    // Resets the design, then runs each test in turn.
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rise = 1'h0;
        code = 12'h000;
        frames = 8'h00;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(32'h53069be2));
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        expect_state(2'h0);
        apb(1'h0, ADDR_CTRL, 32'h0);
        check("ctrl", rd, {30'h0, CTRL_RST});
        $display("test reset done");
        // Loads at every resolution, corner words first, then random ones.
        for (r = 0; r < 4; r++) begin
            res = r[1:0];
            apb(1'h1, ADDR_CTRL, {30'h0, res});
            for (i = 0; i < 5; i++) begin
                w = (i == 0) ? 16'h3FFF : (i == 1) ? 16'h0003 : {2'h0, 14'($urandom())};
                frame({1'h0, w}, 16, 1'h1);
                code = exp_code(w, res);
                expect_state(2'h0);
                apb(1'h0, ADDR_WORD, 32'h0);
                check("word", rd, {16'h0, w});
            end
        end
        apb(1'h1, ADDR_CODE, 32'hFFF);
        apb(1'h0, ADDR_CODE, 32'h0);
        check("code_ro", rd, {20'h0, code});
        $display("test loads done");
        // Frames one bit long and one bit short are refused.
        w = {2'h0, 14'($urandom())};
        frame({w, 1'h1}, 17, 1'h1);
        frame({2'h0, w[15:1]}, 15, 1'h1);
        expect_state(2'h1);
        apb(1'h1, ADDR_STATUS, 32'h6);
        expect_state(2'h0);
        // Reserved commands leave the code alone.
        for (r = 1; r < 3; r++) begin
            frame({1'h0, r[1:0], 14'($urandom())}, 16, 1'h1);
            expect_state(2'h2);
            apb(1'h1, ADDR_STATUS, 32'h6);
        end
        // Clocks without frame select are ignored.
        frame({3'h0, 14'h3FFF}, 16, 1'h0);
        expect_state(2'h0);
        $display("test refusals done");
        // Switch to rising edges, then load in that mode.
        frame({3'h3, 14'h1234}, 16, 1'h1);
        rise = 1'h1;
        expect_state(2'h0);
        for (i = 0; i < 4; i++) begin
            w = (i == 3) ? {2'h3, 14'h0} : {2'h0, 14'($urandom())};
            frame({1'h0, w}, 16, 1'h1);
            code = (i == 3) ? code : exp_code(w, res);
            expect_state(2'h0);
        end
        $display("test rising done");
        // Unmapped address answers with an error and zero data.
        apb(1'h1, 12'h010, 32'hFFFF);
        check("err_wr", {31'h0, err}, 32'h1);
        apb(1'h0, 12'h010, 32'h0);
        check("err_rd", {31'h0, err}, 32'h1);
        check("err_data", rd, 32'h0);
        // A reset in mid-run returns zero scale and falling edges.
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rise = 1'h0;
        code = 12'h000;
        frames = 8'h00;
        expect_state(2'h0);
        w = {2'h0, 14'($urandom())};
        frame({1'h0, w}, 16, 1'h1);
        code = exp_code(w, CTRL_RST);
        expect_state(2'h0);
        $display("test reset again done");
        results();
    end
endmodule : msl_word_loader_bench

// file: verilog/msl_link_if.sv
// Interface carrying shifted words from the serial clock domain to the core.
`timescale 1ns/1ns
interface msl_link_if;
    import msl_pkg::*;
    // Index 0 holds the falling-edge shifter, index 1 the rising-edge one.
    logic [1:0][WORD_BITS-1:0] word;
    logic [1:0][CNT_W-1:0] cnt;
    modport link (output word, output cnt);
    modport core (input word, input cnt);
endinterface : msl_link_if

// file: verilog/msl_link_shift.sv
// Serial shift logic clocked by the link clock on both of its edges.
`timescale 1ns/1ns
module msl_link_shift
    import msl_pkg::*;
(
    input wire logic sclk,
    input wire logic presetn,
    input wire logic sync_n,
    input wire logic serial_data_in,
    msl_link_if.link lk
);

    // ------------------------------------------------------------------
    // One shifter per clock edge
    // ------------------------------------------------------------------
    // Both shifters run in every frame; the core picks the one that
    // matches the active edge, so the edge choice never has to cross
    // into this domain.
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            logic edge_clk;
            logic run_clr;
            logic run_reg;
            logic [WORD_BITS-1:0] word_reg;
            logic [WORD_BITS-1:0] word_next;
            logic [CNT_W-1:0] cnt_reg;
            logic [CNT_W-1:0] cnt_next;

            // Index 1 shifts on rising edges, index 0 on falling edges.
            assign edge_clk = (g == 1) ? sclk : ~sclk;
            // The run flag clears while the frame select is high.
            assign run_clr = sync_n | ~presetn;

            // First bit of a frame restarts the word, later bits shift in.
            always_comb begin
                word_next = word_reg;
                cnt_next = cnt_reg;
                if (!sync_n) begin
                    if (!run_reg) begin
                        word_next = {{(WORD_BITS-1){1'b0}}, serial_data_in};
                        cnt_next = 5'h01;
                    end else begin
                        word_next = {word_reg[WORD_BITS-2:0], serial_data_in};
                        cnt_next = (cnt_reg == CNT_SAT) ? cnt_reg : cnt_reg + 5'h01;
                    end
                end
            end

            // Frame running flag, asynchronously cleared between frames.
            always_ff @(posedge edge_clk or posedge run_clr) begin
                if (run_clr) begin
                    run_reg <= 1'b0;
                end else begin
                    run_reg <= 1'b1;
                end
            end

            // Shift register and bit counter.
            always_ff @(posedge edge_clk or negedge presetn) begin
                if (!presetn) begin
                    word_reg <= 16'h0000;
                    cnt_reg <= 5'h00;
                end else begin
                    word_reg <= word_next;
                    cnt_reg <= cnt_next;
                end
            end

            assign lk.word[g] = word_reg;
            assign lk.cnt[g] = cnt_reg;
        end
    endgenerate

endmodule : msl_link_shift

// file: verilog/msl_pkg.sv
// Package of constants and types for the serial word loader.
package msl_pkg;

    // ------------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [4:0] WORD_CNT_FULL = 5'h10;
    localparam logic [4:0] CNT_SAT = 5'h1F;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 14;
    localparam logic [1:0] CMD_LOAD = 2'h0;
    localparam logic [1:0] CMD_RISE = 2'h3;
    localparam int CODE_W = 12;

    // ------------------------------------------------------------------
    // Resolution choices held in the control register
    // ------------------------------------------------------------------
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;

    // ------------------------------------------------------------------
    // APB register map, fields and reset values
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CODE = 12'h008;
    localparam logic [11:0] ADDR_WORD = 12'h00C;
    localparam int STAT_EDGE_BIT = 0;
    localparam int STAT_LENERR_BIT = 1;
    localparam int STAT_RSVERR_BIT = 2;
    localparam int STAT_CNT_LSB = 8;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [11:0] CODE_RST = 12'h000;

    // Frame handling states, one-hot.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CAPT = 3'h2,
        ST_APPLY = 3'h4
    } msl_state_e;

endpackage : msl_pkg

// file: verilog/msl_word_loader.sv
// Top of the serial word loader: link capture, DAC register and APB slave.
`timescale 1ns/1ns
module msl_word_loader
    import msl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic serial_data_in,
    output logic [11:0] output_current_node,
    output logic edge_rising
);

    // ------------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------------
    msl_link_if lk ();

    // The shifter lives on the serial clock.
    msl_link_shift u_shift (
        .sclk(sclk),
        .presetn(presetn),
        .sync_n(sync_n),
        .serial_data_in(serial_data_in),
        .lk(lk)
    );

    // ------------------------------------------------------------------
    // Frame select synchroniser
    // ------------------------------------------------------------------
    logic sync_s1_reg;
    logic sync_s2_reg;
    logic sync_s3_reg;
    logic sync_rise;

    // Two flops bring the pin in; the third gives the edge detector.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1_reg <= 1'b1;
            sync_s2_reg <= 1'b1;
            sync_s3_reg <= 1'b1;
        end else begin
            sync_s1_reg <= sync_n;
            sync_s2_reg <= sync_s1_reg;
            sync_s3_reg <= sync_s2_reg;
        end
    end

    assign sync_rise = sync_s2_reg & ~sync_s3_reg;

    // ------------------------------------------------------------------
    // Frame handling
    // ------------------------------------------------------------------
    msl_state_e state_reg;
    msl_state_e state_next;
    logic [WORD_BITS-1:0] cap_word_reg;
    logic [WORD_BITS-1:0] cap_word_next;
    logic [CNT_W-1:0] cap_cnt_reg;
    logic [CNT_W-1:0] cap_cnt_next;
    logic [CODE_W-1:0] code_reg;
    logic [CODE_W-1:0] code_next;
    logic edge_reg;
    logic edge_next;
    logic lenerr_reg;
    logic lenerr_next;
    logic rsverr_reg;
    logic rsverr_next;
    logic [7:0] fcnt_reg;
    logic [7:0] fcnt_next;
    logic [1:0] res_reg;
    logic [1:0] res_next;
    logic [1:0] cap_cmd;
    logic cap_ok;
    logic wr_fire;
    logic [31:0] wdata_hold;

    // Pull the code out of a word, MSB aligned below the command.
    function automatic logic [CODE_W-1:0] code_of(input logic [WORD_BITS-1:0] w,
                                                  input logic [1:0] res);
        logic [CODE_W-1:0] c;
        c = 12'h000;
        case (res)
            RES_8: c = {4'h0, w[13:6]};
            RES_10: c = {2'h0, w[13:4]};
            default: c = w[13:2];
        endcase
        return c;
    endfunction : code_of

    assign cap_cmd = cap_word_reg[CMD_MSB:CMD_LSB];
    assign cap_ok = (cap_cnt_reg == WORD_CNT_FULL);

    // Next state of the frame path and of the status it keeps.
    always_comb begin
        state_next = state_reg;
        cap_word_next = cap_word_reg;
        cap_cnt_next = cap_cnt_reg;
        code_next = code_reg;
        edge_next = edge_reg;
        lenerr_next = lenerr_reg;
        rsverr_next = rsverr_reg;
        fcnt_next = fcnt_reg;
        // Software clears error flags by writing ones; a new error wins.
        if (wr_fire && paddr == ADDR_STATUS) begin
            if (wdata_hold[STAT_LENERR_BIT]) begin
                lenerr_next = 1'b0;
            end
            if (wdata_hold[STAT_RSVERR_BIT]) begin
                rsverr_next = 1'b0;
            end
        end
        case (state_reg)
            ST_IDLE: begin
                if (sync_rise) begin
                    state_next = ST_CAPT;
                end
            end
            ST_CAPT: begin
                // The shifters hold their word while frame select is high, so the word is still.
                cap_word_next = lk.word[edge_reg];
                cap_cnt_next = lk.cnt[edge_reg];
                state_next = ST_APPLY;
            end
            ST_APPLY: begin
                fcnt_next = fcnt_reg + 8'h01;
                if (!cap_ok) begin
                    lenerr_next = 1'b1;
                end else begin
                    case (cap_cmd)
                        CMD_LOAD: code_next = code_of(cap_word_reg, res_reg);
                        CMD_RISE: edge_next = 1'b1;
                        default: rsverr_next = 1'b1;
                    endcase
                end
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Frame path registers; reset gives zero scale and falling edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            cap_word_reg <= 16'h0000;
            cap_cnt_reg <= 5'h00;
            code_reg <= CODE_RST;
            edge_reg <= 1'b0;
            lenerr_reg <= 1'b0;
            rsverr_reg <= 1'b0;
            fcnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            cap_word_reg <= cap_word_next;
            cap_cnt_reg <= cap_cnt_next;
            code_reg <= code_next;
            edge_reg <= edge_next;
            lenerr_reg <= lenerr_next;
            rsverr_reg <= rsverr_next;
            fcnt_reg <= fcnt_next;
        end
    end

    assign output_current_node = code_reg;
    assign edge_rising = edge_reg;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic mapped;

    assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                    (paddr == ADDR_CODE) || (paddr == ADDR_WORD);
    assign wr_fire = psel && penable && pready_reg && pwrite && mapped;
    assign wdata_hold = pwdata;

    // Answer in the first access cycle; read data is prepared at setup.
    always_comb begin
        pready_next = psel && !penable;
        pslverr_next = psel && !penable && !mapped;
        prdata_next = prdata_reg;
        res_next = res_reg;
        if (psel && !penable) begin
            case (paddr)
                ADDR_CTRL: prdata_next = {30'h00000000, res_reg};
                ADDR_STATUS: prdata_next = {16'h0000, fcnt_reg, 5'h00, rsverr_reg,
                                            lenerr_reg, edge_reg};
                ADDR_CODE: prdata_next = {20'h00000, code_reg};
                ADDR_WORD: prdata_next = {16'h0000, cap_word_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (wr_fire && paddr == ADDR_CTRL) begin
            res_next = pwdata[1:0];
        end
    end

    // APB answer and control registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            res_reg <= CTRL_RST;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            res_reg <= res_next;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // Frame outcomes that the assertions below look back to.
    logic apply_load;
    logic apply_rise;
    assign apply_load = (state_reg == ST_APPLY) && cap_ok && (cap_cmd == CMD_LOAD);
    assign apply_rise = (state_reg == ST_APPLY) && cap_ok && (cap_cmd == CMD_RISE);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A short word leaves the code alone and raises the length error.
    frame_len_a: assert property ((state_reg == ST_APPLY) && !cap_ok |=>
        $stable(code_reg) && lenerr_reg)
        else $error("short frame changed the code or missed the error");
    // Twelve-bit loads take word bits 13 down to 2.
    res_twelve_a: assert property ((state_reg == ST_APPLY) && cap_ok &&
        cap_cmd == CMD_LOAD && res_reg == RES_12 |=> code_reg == cap_word_reg[13:2])
        else $error("twelve-bit code taken from wrong bits");
    // Ten-bit loads take word bits 13 down to 4.
    res_ten_a: assert property ((state_reg == ST_APPLY) && cap_ok &&
        cap_cmd == CMD_LOAD && res_reg == RES_10 |=>
        code_reg == {2'h0, cap_word_reg[13:4]})
        else $error("ten-bit code taken from wrong bits");
    // Eight-bit loads take word bits 13 down to 6.
    res_eight_a: assert property ((state_reg == ST_APPLY) && cap_ok &&
        cap_cmd == CMD_LOAD && res_reg == RES_8 |=>
        code_reg == {4'h0, cap_word_reg[13:6]})
        else $error("eight-bit code taken from wrong bits");
    // The rising edge is chosen only by a whole command frame.
    edge_cause_a: assert property ($rose(edge_reg) |->
        $past(apply_rise))
        else $error("edge changed without a rise command");
    // The edge change frame leaves the code untouched.
    edge_hold_a: assert property ((state_reg == ST_APPLY) && cap_ok &&
        cap_cmd == CMD_RISE |=> $stable(code_reg))
        else $error("edge change frame updated the code");
    // Once rising, the edge stays rising until reset.
    edge_stick_a: assert property (edge_reg |=> edge_reg)
        else $error("edge selection reverted without reset");
    // The code moves only on an applied load frame.
    code_cause_a: assert property ($changed(code_reg) |->
        $past(apply_load))
        else $error("code changed without a load frame");
    // A frame select rise is captured and applied in the next two cycles.
    sync_apply_a: assert property (sync_rise && state_reg == ST_IDLE |=>
        state_reg == ST_CAPT ##1 state_reg == ST_APPLY)
        else $error("frame end not applied in time");

    load_seen_c: cover property ((state_reg == ST_APPLY) && cap_ok && cap_cmd == CMD_LOAD);
    rise_seen_c: cover property ($rose(edge_reg));
    short_seen_c: cover property ((state_reg == ST_APPLY) && !cap_ok);
    rsv_seen_c: cover property ($rose(rsverr_reg));

endmodule : msl_word_loader
